// *** rtl/tws_slave.sv ***
// Function
// - misplaced start/stop: error flag, idle till start
// - read address: transmitter, direction flag set later
// - write address: receiver, direction flag cleared later
// - transmitter waits for holding data, then requests
// - check byte sent when counter zero, no stretch
// - byte counter counts up or down per byte
// - nak flag two cycles after clock high
// - byte done: transmitter two cycles after ack clock low, receiver one cycle after eighth clock low
// - stop in transmitter: complete and stop flags
// - repeated start after addressing sets flag
// - release data on ninth pulse, sample ack
// - receiver shifts byte, then byte done
// - receiver acks data per control field
// - check byte acked only when crc matches
// - check byte mismatch sets error flag
// - stop in receiver sets complete flag
// - receive request doubles as dma request
// - transmit request doubles as dma request
// - smbus mode accepts seven-bit addresses only
// - crc always updated, checking only when enabled
// - timeout base is clock over 2^(exp+1)
// - no stretch: overrun discards, underrun resends
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "tws_defs.svh"

module tws_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic alert_o,
    output logic alert_oe_o,
    output logic dma_tx_req_o,
    output logic dma_rx_req_o
);
    tws_pkg::tws_ctrl_t ctrl;
    tws_pkg::tws_timing_t timing;
    tws_pkg::tws_flags_t flags;
    tws_pkg::tws_state_t state;
    logic [7:0] byte_counter;
    logic [7:0] receive_holding_buffer;
    logic [7:0] transmit_holding_buffer;
    logic thr_full;
    logic rhr_full;
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic [7:0] crc;
    logic addressed;
    logic tra_pend, tra_val;
    logic nak_pend, nak_val, btf_pend;
    logic [15:0] presc;
    logic [15:0] tcount;
    logic wr, rd_rhr, wr_thr;
    logic scl_rise, scl_fall, start_c, stop_c, timeout;
    logic pec_on, tx_pec, tx_load;
    logic [7:0] next_byte_counter;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [7:0] next_crc;
    logic [7:0] stored;

    // bus access decode
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    assign rd_rhr = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o & (wb_adr_i == `TWS_OFS_RHR);
    assign wr_thr = wr & wb_sel_i[0] & (wb_adr_i == `TWS_OFS_THR);

    // two-flop synchronisers, third flop for edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_c = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
    assign pec_on = ctrl.smbus_mode_select & ctrl.packet_check_enable;
    assign tx_pec = pec_on & (byte_counter == 8'h00);
    assign next_byte_counter = ctrl.count_up_select ? byte_counter + 8'h01 : byte_counter - 8'h01;
    // crc-8 over the bus level, one bit per rising clock
    assign next_crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ sda_s) ? `TWS_CRC_POLY : 8'h00);

    // control and timing registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `TWS_CTRL_RST;
            timing <= `TWS_TIMING_RST;
        end else if (wr) begin
            if (wb_adr_i == `TWS_OFS_CTRL) begin
                for (int i = 0; i < 4; i++) begin
                    if (wb_sel_i[i]) ctrl[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                end
            end
            if (wb_adr_i == `TWS_OFS_TIMING) begin
                for (int i = 0; i < 4; i++) begin
                    if (wb_sel_i[i]) timing[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                end
            end
        end
    end

    // registered read mux and single-wait ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            case (wb_adr_i)
                `TWS_OFS_CTRL: wb_dat_o <= ctrl;
                `TWS_OFS_BYTE_COUNTER: wb_dat_o <= {24'h00_0000, byte_counter};
                `TWS_OFS_TIMING: wb_dat_o <= timing;
                `TWS_OFS_STATUS: wb_dat_o <= flags;
                `TWS_OFS_RHR: wb_dat_o <= {24'h00_0000, receive_holding_buffer};
                `TWS_OFS_THR: wb_dat_o <= {24'h00_0000, transmit_holding_buffer};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // prescaled tick and low-period timeout counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc <= 16'h0000;
            tcount <= 16'h0000;
        end else begin
            // wraps every 2^(exp+1) clocks
            presc <= (presc + 16'h0001) & ((16'h0002 << timing.prescale_power) - 16'h0001);
            if (scl_s || state == tws_pkg::ST_IDLE || timeout) begin
                tcount <= 16'h0000;
            end else if (presc == 16'h0000) begin
                tcount <= tcount + 16'h0001;
            end
        end
    end

    assign timeout = ctrl.smbus_mode_select & (timing.timeout_ticks != 16'h0000)
        & (tcount >= timing.timeout_ticks);

    // hardware-set status events, collected per cycle
    always_comb begin
        set_bits = 32'h0000_0000;
        set_bits[8] = 1'b0;
        if (nak_pend && nak_val) set_bits[7] = 1'b1;
        if (btf_pend) set_bits[6] = 1'b1;
        if (timeout) set_bits[10] = 1'b1;
        if (start_c || stop_c) begin
            if (state != tws_pkg::ST_IDLE && state != tws_pkg::ST_WAIT && bitcnt > 4'h1
                && bitcnt != 4'h8) begin // one rise is legal: a stop or restart follows the ack
                set_bits[8] = 1'b1;
            end else if (addressed && start_c) begin
                set_bits[5] = 1'b1;
            end else if (addressed && stop_c) begin
                set_bits[3] = 1'b1;
                set_bits[4] = 1'b1;
            end
        end
        if (state == tws_pkg::ST_ADDR && scl_fall && bitcnt == 4'h8 && stored[0]) set_bits[13] = 1'b1;
        if (state == tws_pkg::ST_RX && scl_fall && bitcnt == 4'h8) begin
            set_bits[6] = 1'b1;
            if (pec_on && next_byte_counter == 8'h00 && crc != 8'h00) set_bits[9] = 1'b1;
            if (rhr_full && !ctrl.stretch_enable) set_bits[12] = 1'b1;
        end
        if (tx_load && !tx_pec && !thr_full && !ctrl.stretch_enable) set_bits[11] = 1'b1;
        clr_bits = (wr && wb_adr_i == `TWS_OFS_STATUS) ? (wb_dat_i & `TWS_STATUS_W1C) : 32'h0000_0000;
    end

    // address match: own address, plus alert response when alerting
    always_comb begin
        stored = 8'h00;
        if (ctrl.enable && shreg[7:1] == ctrl.slave_addr
            && !(ctrl.smbus_mode_select && shreg[7:3] == `TWS_TENBIT_HDR)) begin
            stored[0] = 1'b1;
        end
        if (ctrl.enable && ctrl.smbus_mode_select && ctrl.alert && shreg[7:1] == `TWS_ARA_ADDR) begin
            stored[0] = 1'b1;
        end
        stored[7:1] = 7'h00;
    end

    // load point of a transmit byte: after each acked ninth clock
    assign tx_load = (scl_fall && ((state == tws_pkg::ST_AACK && tra_val)
        || (state == tws_pkg::ST_TACK && !nak_val))) || (state == tws_pkg::ST_TXW && thr_full);

    // status flags: set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= 32'h0000_0002;
        end else begin
            flags <= (flags & ~clr_bits) | set_bits;
            flags.direction_read_flag <= tra_pend ? tra_val : flags.direction_read_flag;
            flags.receive_request_flag <= rhr_full;
            flags.transmit_request_flag <= ~thr_full;
        end
    end

    // holding buffers between software or dma and the shifter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transmit_holding_buffer <= 8'h00;
            thr_full <= 1'b0;
        end else if (wr_thr) begin
            transmit_holding_buffer <= wb_dat_i[7:0];
            thr_full <= 1'b1;
        end else if (tx_load && !tx_pec && thr_full) begin
            thr_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            receive_holding_buffer <= 8'h00;
            rhr_full <= 1'b0;
        end else if ((state == tws_pkg::ST_RX && scl_fall && bitcnt == 4'h8 && !rhr_full)
            || (state == tws_pkg::ST_RXW && !rhr_full)) begin
            receive_holding_buffer <= shreg;
            rhr_full <= 1'b1;
        end else if (rd_rhr) begin
            rhr_full <= 1'b0;
        end
    end

    // byte counter, software writes take priority
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            byte_counter <= `TWS_BYTE_COUNTER_RST;
        end else if (wr && wb_sel_i[0] && wb_adr_i == `TWS_OFS_BYTE_COUNTER) begin
            byte_counter <= wb_dat_i[7:0];
        end else if ((state == tws_pkg::ST_TX || state == tws_pkg::ST_RX) && scl_fall && bitcnt == 4'h8) begin
            byte_counter <= next_byte_counter;
        end
    end

    // delayed flag pulses give the two-cycle offsets
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nak_pend <= 1'b0;
            btf_pend <= 1'b0;
            tra_pend <= 1'b0;
        end else begin
            nak_pend <= state == tws_pkg::ST_TACK && scl_rise;
            btf_pend <= state == tws_pkg::ST_TACK && scl_fall;
            tra_pend <= set_bits[13];
        end
    end

    // crc runs on every data and address bit, enabled or not
    always_ff @(posedge clk_i) begin
        if (rst_i || start_c) begin
            crc <= `TWS_CRC_INIT;
        end else if (scl_rise && bitcnt != 4'h8 && state != tws_pkg::ST_IDLE && state != tws_pkg::ST_WAIT
            && state != tws_pkg::ST_AACK && state != tws_pkg::ST_RACK && state != tws_pkg::ST_TACK) begin
            crc <= next_crc;
        end
    end

    // bit engine: shifter, bit count, line drives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= tws_pkg::ST_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            addressed <= 1'b0;
            tra_val <= 1'b0;
            nak_val <= 1'b0;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end else if (timeout || set_bits[8]) begin
            state <= tws_pkg::ST_IDLE;
            addressed <= 1'b0;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end else if (start_c) begin
            state <= tws_pkg::ST_ADDR;
            bitcnt <= 4'h0;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end else if (stop_c) begin
            state <= tws_pkg::ST_IDLE;
            addressed <= 1'b0;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end else begin
            case (state)
                tws_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        if (stored[0]) begin
                            state <= tws_pkg::ST_AACK;
                            addressed <= 1'b1;
                            tra_val <= shreg[0];
                            sda_oe_o <= 1'b1;
                        end else begin
                            state <= tws_pkg::ST_WAIT;
                        end
                    end
                end
                tws_pkg::ST_AACK, tws_pkg::ST_TACK, tws_pkg::ST_TXW: begin
                    if (state == tws_pkg::ST_TACK && scl_rise) nak_val <= sda_s;
                    if (tx_load) begin
                        state <= tws_pkg::ST_TX;
                        bitcnt <= 4'h0;
                        // pec byte, fresh data, or the stale byte again
                        shreg <= tx_pec ? crc : transmit_holding_buffer;
                        sda_oe_o <= tx_pec ? ~crc[7] : ~transmit_holding_buffer[7];
                    end else if (scl_fall && state == tws_pkg::ST_TACK) begin
                        state <= tws_pkg::ST_WAIT;
                        sda_oe_o <= 1'b0;
                    end else if (scl_fall && state == tws_pkg::ST_AACK) begin
                        state <= tws_pkg::ST_RX;
                        bitcnt <= 4'h0;
                        sda_oe_o <= 1'b0;
                    end
                    // write address ack lets the clock go; empty holding buffer with stretching on stalls
                    if (scl_fall && !tra_val && state == tws_pkg::ST_AACK) begin
                        scl_oe_o <= 1'b0;
                    end else if (scl_fall && !tx_pec && !thr_full && ctrl.stretch_enable
                        && (state == tws_pkg::ST_TACK ? !nak_val : tra_val)) begin
                        state <= tws_pkg::ST_TXW;
                        sda_oe_o <= 1'b0;
                        scl_oe_o <= 1'b1;
                    end
                end
                tws_pkg::ST_TX: begin
                    scl_oe_o <= 1'b0; // stretch ends a clock after the msb is set up
                    if (scl_rise) begin
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bitcnt == 4'h8) begin
                            state <= tws_pkg::ST_TACK;
                            sda_oe_o <= 1'b0;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                            sda_oe_o <= ~shreg[6];
                        end
                    end
                end
                tws_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        if (rhr_full && ctrl.stretch_enable) begin
                            state <= tws_pkg::ST_RXW;
                            scl_oe_o <= 1'b1;
                        end else begin
                            state <= tws_pkg::ST_RACK;
                            if (pec_on && next_byte_counter == 8'h00) begin
                                sda_oe_o <= crc == 8'h00;
                            end else begin
                                sda_oe_o <= ~ctrl.nak_resp;
                            end
                        end
                    end
                end
                tws_pkg::ST_RXW: begin
                    // counter already moved, so zero marks the pec byte
                    if (!rhr_full) begin
                        state <= tws_pkg::ST_RACK;
                        sda_oe_o <= (pec_on && byte_counter == 8'h00) ? crc == 8'h00 : ~ctrl.nak_resp;
                    end
                end
                tws_pkg::ST_RACK: begin
                    scl_oe_o <= 1'b0; // ack level settles before the clock is let go
                    if (scl_fall) begin
                        state <= tws_pkg::ST_RX;
                        bitcnt <= 4'h0;
                        sda_oe_o <= 1'b0;
                    end
                end
                default: begin
                    // idle: only a start leaves; wait: a start, stop or timeout leaves
                    sda_oe_o <= 1'b0;
                    scl_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // open-drain levels and the alert line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            alert_o <= 1'b0;
            alert_oe_o <= 1'b0;
            dma_tx_req_o <= 1'b0;
            dma_rx_req_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            alert_o <= 1'b0;
            alert_oe_o <= ctrl.alert & ctrl.smbus_mode_select;
            dma_tx_req_o <= ~thr_full;
            dma_rx_req_o <= rhr_full;
        end
    end

endmodule // tws_slave

// *** rtl/tws_defs.svh ***
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

// register word offsets
`define TWS_OFS_CTRL 4'h0
`define TWS_OFS_BYTE_COUNTER 4'h1
`define TWS_OFS_TIMING 4'h2
`define TWS_OFS_STATUS 4'h3
`define TWS_OFS_RHR 4'h4
`define TWS_OFS_THR 4'h5

// reset values
`define TWS_CTRL_RST 32'h0000_0000
`define TWS_TIMING_RST 32'h0000_0000
`define TWS_BYTE_COUNTER_RST 8'h00

// status bits cleared by writing one
`define TWS_STATUS_W1C 32'h0000_3ff8

// fixed bus addresses and crc
`define TWS_ARA_ADDR 7'h0c
`define TWS_TENBIT_HDR 5'h1e
`define TWS_CRC_POLY 8'h07
`define TWS_CRC_INIT 8'h00

`endif

// *** rtl/tws_pkg.sv ***
package tws_pkg;

    // control register image
    typedef struct packed {
        logic [16:0] unused;
        logic [6:0] slave_addr;
        logic unused_b7;
        logic alert;
        logic stretch_enable;
        logic nak_resp;
        logic count_up_select;
        logic packet_check_enable;
        logic smbus_mode_select;
        logic enable;
    } tws_ctrl_t;

    // timing register image
    typedef struct packed {
        logic [11:0] unused;
        logic [3:0] prescale_power;
        logic [15:0] timeout_ticks;
    } tws_timing_t;

    // status flags, top bit first down to bit 0
    typedef struct packed {
        logic [17:0] unused;
        logic addr_match;
        logic overrun_flag;
        logic underrun_flag;
        logic bus_timeout_flag;
        logic packet_check_error_flag;
        logic bus_error_flag;
        logic nak;
        logic byte_done_flag;
        logic restart_seen_flag;
        logic end_condition_flag;
        logic transfer_complete_flag;
        logic direction_read_flag;
        logic transmit_request_flag;
        logic receive_request_flag;
    } tws_flags_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_TX, ST_TXW, ST_TACK, ST_RX, ST_RXW, ST_RACK, ST_WAIT
    } tws_state_t;

endpackage

// *** verification/tws_slave_sva.sv ***
`timescale 1ns/1ps
module tws_slave_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic scl_i,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    input wire logic alert_oe_o,
    input wire logic dma_tx_req_o,
    input wire logic dma_rx_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic alert_exp;
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr_ctrl = req && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0];
    // alert level expected from the last control write
    always_ff @(posedge clk_i) begin
        if (wr_ctrl) begin
            alert_exp <= wb_dat_i[6] & wb_dat_i[1];
        end
    end
    // bus answer timing
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ack_answer: assert property (req |=> wb_ack_o) else $error("ack missing");
    // outputs after reset release, an rhr read and a control write
    a_idle_release: assert property ($fell(rst_i) |-> !sda_oe_o && !scl_oe_o && !alert_oe_o)
        else $error("lines driven after reset");
    a_tx_req_reset: assert property ($fell(rst_i) |=> dma_tx_req_o)
        else $error("tx request not raised");
    a_rx_req_drop: assert property (req && !wb_we_i && wb_adr_i == 4'h4 |=> ##[0:1] !dma_rx_req_o)
        else $error("rx request not dropped");
    a_alert_write: assert property (wr_ctrl |=> ##1 alert_oe_o == alert_exp)
        else $error("alert drive wrong");
    // line drives begin only while the clock is low
    a_stretch_low: assert property ($rose(scl_oe_o) |-> !$past(scl_i))
        else $error("stretch with clock high");
    a_ack_drive_low: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i))
        else $error("data pulled with clock high");
endmodule // tws_slave_sva

bind tws_slave tws_slave_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .scl_i(scl_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .alert_oe_o(alert_oe_o),
    .dma_tx_req_o(dma_tx_req_o), .dma_rx_req_o(dma_rx_req_o));

// *** verification/tws_mstr.sv ***
`timescale 1ns/1ps
module tws_mstr (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    localparam int HP = 10;
    // lines released, pull-ups give idle high
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one pulse; a slave stretch holds the high phase back
    task automatic bit_io(input logic b, output logic s);
        sda_oe_o <= !b;
        tick(HP);
        scl_oe_o <= 1'b0;
        tick(2);
        for (int i = 0; i < 5000 && !scl_i; i++) tick(1);
        tick(HP);
        s = sda_i;
        scl_oe_o <= 1'b1;
        tick(HP);
    endtask
    // eight bits msb first plus the ack pulse
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bit_io(d[i], q[i]);
    endtask
    // start or repeated start
    task automatic start();
        sda_oe_o <= 1'b0;
        tick(HP);
        scl_oe_o <= 1'b0;
        tick(HP);
        sda_oe_o <= 1'b1;
        tick(HP);
        scl_oe_o <= 1'b1;
        tick(HP);
    endtask
    task automatic stop();
        sda_oe_o <= 1'b1;
        tick(HP);
        scl_oe_o <= 1'b0;
        tick(HP);
        sda_oe_o <= 1'b0;
        tick(HP);
    endtask
endmodule // tws_mstr

// *** verification/test_two_wire_slave_transfer_engine.sv ***
`timescale 1ns/1ps
module test_two_wire_slave_transfer_engine;
    typedef struct packed {logic [31:0] e; logic [31:0] m;} tws_exp_t;
    localparam logic [6:0] SADR = 7'h2a;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, dat_o;
    logic ack, scl_oe, sda_oe, alert_oe, m_scl, m_sda;
    logic [8:0] r;
    logic [7:0] d, c;
    int fails = 0, n_checks = 0;
    tws_exp_t q[$];
    tws_exp_t x;
    wire logic scl = !(m_scl | scl_oe);
    wire logic sda = !(m_sda | sda_oe);
    always #10 clk_i = !clk_i;
    tws_slave dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .scl_i(scl), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .alert_o(), .alert_oe_o(alert_oe),
        .dma_tx_req_o(), .dma_rx_req_o());
    tws_mstr mst (.clk_i(clk_i), .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl), .sda_oe_o(m_sda));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chkb(input string nm, input logic [8:0] e, input logic [8:0] s);
        chk(nm, {23'h0, e}, {23'h0, s});
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        sel <= 4'hf;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        q.push_back('{e, m});
        wb(1'b0, a, 32'h0);
    endtask
    // read results taken off the queue as they appear
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
            x = q.pop_front();
            chk("read data", x.e & x.m, dat_o & x.m);
        end
    end
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // a hang costs far more than the ~5k cycles of the sequence
    initial begin
        repeat (60000) @(posedge clk_i);
        fails++;
        print_verdict();
    end
    initial begin
        void'($urandom(29));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h3, 32'h2, 32'h3fff);
        rd(4'hf, 32'h0, 32'hffffffff);
        // receiver counting up; second byte meets a full buffer and a nak setting
        wb(1'b1, 4'h0, {17'h0, SADR, 8'h09});
        wb(1'b1, 4'h1, 32'h0);
        d = 8'($urandom);
        mst.start();
        mst.xfer({SADR, 2'b01}, r);
        mst.xfer({d, 1'b1}, r);
        chkb("write byte", {d, 1'b0}, r);
        rd(4'h3, 32'h2043, 32'h2047);
        wb(1'b1, 4'h0, {17'h0, SADR, 8'h19});
        mst.xfer({~d, 1'b1}, r);
        chkb("refused byte", {~d, 1'b1}, r);
        rd(4'h4, {24'h0, d}, 32'hff);
        rd(4'h1, 32'h2, 32'hff);
        mst.stop();
        rd(4'h3, 32'h1018, 32'h101d);
        wb(1'b1, 4'h3, 32'h3ff8);
        $display("receiver done");
        // transmitter stalls on an empty buffer, then sends the check byte
        wb(1'b1, 4'h0, {17'h0, SADR, 8'h27});
        wb(1'b1, 4'h1, 32'h1);
        d = 8'($urandom);
        c = crc8(crc8(8'h00, {SADR, 1'b1}), d);
        mst.start();
        mst.xfer({SADR, 2'b11}, r);
        chkb("read address", {SADR, 2'b10}, r);
        fork
            mst.xfer(9'h1fe, r);
            begin
                mst.tick(400);
                wb(1'b1, 4'h5, {24'h0, d});
            end
        join
        chkb("held byte", {d, 1'b0}, r);
        mst.xfer(9'h1ff, r);
        chkb("check byte", {c, 1'b1}, r);
        rd(4'h3, 32'h00c6, 32'h00c6);
        mst.stop();
        rd(4'h3, 32'h0018, 32'h0018);
        wb(1'b1, 4'h3, 32'h3ff8);
        $display("transmitter done");
        // receiver check byte right then wrong; second pass opens with a repeated start
        wb(1'b1, 4'h0, {17'h0, SADR, 8'h07});
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, 4'h1, 32'h2);
            d = 8'($urandom);
            c = crc8(crc8(8'h00, {SADR, 1'b0}), d) ^ k[7:0];
            mst.start();
            mst.xfer({SADR, 2'b01}, r);
            mst.xfer({d, 1'b1}, r);
            rd(4'h4, {24'h0, d}, 32'hff);
            mst.xfer({c, 1'b1}, r);
            chkb("check ack", {c, k[0]}, r);
            rd(4'h3, {22'h0, k[0], 3'h0, k[0], 5'h0}, 32'h220);
            rd(4'h4, {24'h0, c}, 32'hff);
        end
        mst.stop();
        wb(1'b1, 4'h3, 32'h3ff8);
        $display("check byte done");
        // stop in the middle of the address
        mst.start();
        repeat (3) mst.bit_io(1'b1, r[0]);
        mst.stop();
        rd(4'h3, 32'h100, 32'h100);
        // alert drive, alert address, wide header refused
        wb(1'b1, 4'h0, {17'h0, 7'h78, 8'h43});
        mst.tick(2);
        chkb("alert line", 9'h1, {8'h0, alert_oe});
        mst.start();
        mst.xfer({7'h0c, 2'b01}, r);
        chkb("alert address", {7'h0c, 2'b00}, r);
        mst.start();
        mst.xfer({7'h78, 2'b01}, r);
        chkb("wide header", {7'h78, 2'b01}, r);
        mst.stop();
        // short timeout, then the clock held low after a start
        wb(1'b1, 4'h2, 32'h0001_0004);
        mst.start();
        mst.tick(40);
        rd(4'h3, 32'h400, 32'h400);
        $display("bus events done");
        print_verdict();
    end
endmodule // test_two_wire_slave_transfer_engine
